// [hw/xbp_crossbar.sv]
// partially connected crossbar with fixed-priority target arbitration
`timescale 1ns/1ps
module xbp_crossbar
    import xbp_pkg::*;
(
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    input  wire xbp_pkg::xbp_req_s [2:0]     M_REQ,
    output logic                   [2:0]     M_GNT,
    output logic                   [2:0]     M_ERR,
    input  wire logic              [2:0]     T_READY,
    output xbp_pkg::xbp_tgt_s      [2:0]     T_REQ,
    input  wire logic                        CORE_D0_REQ,
    input  wire logic                        CORE_D1_REQ,
    input  wire logic                        FETCH_REQ,
    output logic                   [3:0]     MC_GNT,
    input  wire logic                        HOST_WIN_EN,
    input  wire logic                        PAGE_WR,
    input  wire logic [xbp_pkg::PAGE_W-1:0]  PAGE_VAL,
    output logic      [xbp_pkg::PAGE_W-1:0]  HOST_PAGE
);
    import xbp_pkg::*;

    // ********************************************************************
    // host page register
    // ********************************************************************
    logic [PAGE_W-1:0] page;
    logic              win_en;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            page   <= PAGE_RST;
            win_en <= 1'b0;
        end else if (PAGE_WR) begin
            page   <= PAGE_VAL;
            win_en <= HOST_WIN_EN;
        end
    end

    assign HOST_PAGE = page;

    // ********************************************************************
    // request decode
    // ********************************************************************
    logic [NUM_M-1:0][1:0]       tsel;
    logic                        host_bad;
    logic [NUM_T-1:0][NUM_M-1:0] eff_req;
    logic [NUM_T-1:0][NUM_M-1:0] win;

    always_comb begin
        for (int m = 0; m < NUM_M; m++) begin
            tsel[m] = xbp_target(M_REQ[m].addr);
        end
    end

    assign host_bad = M_REQ[M_HPM].valid &&
                      (tsel[M_HPM] == 2'(T_PER) ||
                       (win_en && M_REQ[M_HPM].addr[ADDR_W-1:PAGE_LSB] != page));

    always_comb begin
        for (int t = 0; t < NUM_T; t++) begin
            for (int m = 0; m < NUM_M; m++) begin
                eff_req[t][m] = M_REQ[m].valid && tsel[m] == 2'(t) &&
                                !(m == M_HPM && host_bad);
            end
        end
    end

    // ********************************************************************
    // per-target arbitration
    // ********************************************************************
    // independent arbiter per target
    always_comb begin
        for (int t = 0; t < NUM_T; t++) begin
            win[t] = xbp_fixed_pri(eff_req[t]) & {NUM_M{T_READY[t]}};
        end
    end

    // refused host requests are consumed so the host does not hang
    always_comb begin
        for (int m = 0; m < NUM_M; m++) begin
            M_GNT[m] = 1'b0;
            for (int t = 0; t < NUM_T; t++) begin
                M_GNT[m] = M_GNT[m] | win[t][m];
            end
        end
        M_GNT[M_HPM] = M_GNT[M_HPM] | host_bad;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            M_ERR <= '0;
        end else begin
            M_ERR        <= '0;
            M_ERR[M_HPM] <= host_bad;
        end
    end

    // ********************************************************************
    // target side registers
    // ********************************************************************
    xbp_tgt_s [NUM_T-1:0] next_treq;

    always_comb begin
        for (int t = 0; t < NUM_T; t++) begin
            next_treq[t] = '0;
            for (int m = 0; m < NUM_M; m++) begin
                if (win[t][m]) begin
                    next_treq[t].valid = 1'b1;
                    next_treq[t].write = M_REQ[m].write;
                    next_treq[t].addr  = M_REQ[m].addr;
                    next_treq[t].wdata = M_REQ[m].wdata;
                    next_treq[t].src   = 2'(m);
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            T_REQ <= '0;
        end else begin
            T_REQ <= next_treq;
        end
    end

    // ********************************************************************
    // memory controller
    // ********************************************************************
    // shared 32-bit port is the crossbar memory target
    xbp_memctl #(
        .SLOTS (MC_SLOTS)
    ) u_memctl (
        .CLK   (CLK),
        .RESET (RESET),
        .REQ   ({FETCH_REQ, T_REQ[T_MEM].valid, CORE_D1_REQ, CORE_D0_REQ}),
        .GNT   (MC_GNT)
    );

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_one_owner: assert property (
        $onehot0(win[T_MEM]) && $onehot0(win[T_PER]) && $onehot0(win[T_EXT]))
        else $error("two masters own one target");

    a_dme_first: assert property (
        eff_req[T_EXT][M_DME] && T_READY[T_EXT] |-> win[T_EXT] == 3'b100)
        else $error("engine lost to lower master");

    a_hpm_over_core: assert property (
        eff_req[T_MEM][M_HPM] && !eff_req[T_MEM][M_DME] && T_READY[T_MEM]
        |-> win[T_MEM] == 3'b010)
        else $error("host lost to core");

    a_parallel_go: assert property (
        eff_req[T_EXT][M_CORE] && eff_req[T_MEM][M_DME] && T_READY[T_EXT] && T_READY[T_MEM]
        && !eff_req[T_EXT][M_HPM] && !eff_req[T_EXT][M_DME] |-> M_GNT[M_CORE] && M_GNT[M_DME])
        else $error("disjoint transfers serialised");

    a_no_host_per: assert property (
        M_REQ[M_HPM].valid && tsel[M_HPM] == 2'(T_PER)
        |-> !win[T_PER][M_HPM] ##1 M_ERR[M_HPM] && T_REQ[T_PER].src != 2'(M_HPM))
        else $error("host reached a peripheral");

    a_page_stable: assert property (
        !PAGE_WR |=> $stable(HOST_PAGE))
        else $error("page changed without core write");

    a_host_window: assert property (
        win_en && win[T_MEM][M_HPM] |=> T_REQ[T_MEM].addr[ADDR_W-1:PAGE_LSB] == $past(page))
        else $error("host left its page");

    a_loser_cause: assert property (
        eff_req[T_EXT][M_CORE] && !M_GNT[M_CORE]
        |-> !T_READY[T_EXT] || eff_req[T_EXT][M_HPM] || eff_req[T_EXT][M_DME])
        else $error("core stalled without cause");

    a_tgt_issue: assert property (
        win[T_MEM][M_DME] |=> T_REQ[T_MEM].valid && T_REQ[T_MEM].src == 2'(M_DME))
        else $error("shared port owner wrong");

    c_contend: cover property (eff_req[T_EXT] == 3'b111 && T_READY[T_EXT]);
    c_parallel: cover property ($countones(M_GNT) == NUM_M);
    c_host_err: cover property (M_ERR[M_HPM]);
    c_stall_then_go: cover property (eff_req[T_EXT][M_CORE] && !M_GNT[M_CORE] ##1 M_GNT[M_CORE]);

endmodule : xbp_crossbar

// [pkg/xbp_pkg.sv]
// shared constants, carriers and helpers for the crossbar priority arbiter
package xbp_pkg;

    // ********************************************************************
    // sizes and indices
    // ********************************************************************
    localparam int          NUM_M      = 3;
    localparam int          NUM_T      = 3;
    localparam int          ADDR_W     = 32;
    localparam int          DATA_W     = 32;
    localparam int          PAGE_W     = 16;
    localparam int          PAGE_LSB   = 16;
    localparam int          MC_SRC     = 4;
    localparam int          MC_SLOTS   = 3;
    localparam int          CORE_DW    = 64;
    localparam int          FETCH_DW   = 256;
    localparam int          PSS_DW     = 32;

    // master indices, higher index is higher priority
    localparam int          M_CORE     = 0;
    localparam int          M_HPM      = 1;
    localparam int          M_DME      = 2;

    // target indices
    localparam int          T_MEM      = 0;
    localparam int          T_PER      = 1;
    localparam int          T_EXT      = 2;

    // memory controller source indices
    localparam int          MC_D0      = 0;
    localparam int          MC_D1      = 1;
    localparam int          MC_PSS     = 2;
    localparam int          MC_FETCH   = 3;

    // ********************************************************************
    // address regions (top nibble) and reset values
    // ********************************************************************
    localparam logic [3:0]        REG_MEM   = 4'h0;
    localparam logic [3:0]        REG_PER   = 4'h4;
    localparam logic [PAGE_W-1:0] PAGE_RST  = 16'h0000;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } xbp_req_s;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        src;
    } xbp_tgt_s;

    // ********************************************************************
    // helpers
    // ********************************************************************
    function automatic logic [1:0] xbp_target(input logic [ADDR_W-1:0] a);
        if (a[ADDR_W-1 -: 4] == REG_MEM) begin
            return 2'(T_MEM);
        end else if (a[ADDR_W-1 -: 4] == REG_PER) begin
            return 2'(T_PER);
        end else begin
            return 2'(T_EXT);
        end
    endfunction : xbp_target

    // highest index wins, never rotates
    function automatic logic [NUM_M-1:0] xbp_fixed_pri(input logic [NUM_M-1:0] r);
        logic [NUM_M-1:0] g;
        g = '0;
        for (int i = NUM_M - 1; i >= 0; i--) begin
            if (r[i] && g == '0) begin
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction : xbp_fixed_pri

endpackage : xbp_pkg

// [hw/xbp_memctl.sv]
// on-chip memory controller slot allocator, three of four sources per cycle
`timescale 1ns/1ps
module xbp_memctl
    import xbp_pkg::*;
#(
    parameter int SLOTS = MC_SLOTS
) (
    input  wire logic              CLK,
    input  wire logic              RESET,
    input  wire logic [MC_SRC-1:0] REQ,
    output logic      [MC_SRC-1:0] GNT
);
    import xbp_pkg::*;

    // ********************************************************************
    // slot allocation
    // ********************************************************************
    // at most three slots
    always_comb begin
        int used;
        used = 0;
        GNT  = '0;
        for (int i = 0; i < MC_SRC; i++) begin
            if (REQ[i] && used < SLOTS) begin
                GNT[i] = 1'b1;
                used   = used + 1;
            end
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    a_slot_limit: assert property (@(posedge CLK) disable iff (RESET)
        $countones(GNT) <= SLOTS && (GNT & ~REQ) == '0)
        else $error("memory slots oversubscribed");

    a_core_single: assert property (@(posedge CLK) disable iff (RESET)
        REQ[MC_D0] |-> GNT[MC_D0] && (REQ[MC_D1] == GNT[MC_D1]))
        else $error("core data access not single cycle");

    a_three_served: assert property (@(posedge CLK) disable iff (RESET)
        $countones(REQ) >= SLOTS |-> $countones(GNT) == SLOTS)
        else $error("parallel slots left idle");

    c_all_four: cover property (@(posedge CLK) disable iff (RESET) REQ == '1);

endmodule : xbp_memctl

// [dv/xbp_tgt_model.sv]
// target-side model: answers promptly, or stalls two cycles after each transfer
`timescale 1ns/1ps
module xbp_tgt_model
    import xbp_pkg::*;
(
    input  wire logic                    CLK,
    input  wire logic                    RESET,
    input  wire logic                    SLOW,
    input  wire xbp_pkg::xbp_tgt_s [2:0] T_REQ,
    output logic                   [2:0] T_READY
);
    import xbp_pkg::*;
    // ****************************************
    // busy window per target
    // ****************************************
    logic [1:0] busy [3];
    always_ff @(posedge CLK) begin
        for (int t = 0; t < 3; t++) begin
            if (RESET) begin
                busy[t] <= 2'h0;
            end else if (T_REQ[t].valid) begin
                busy[t] <= 2'h2;
            end else if (busy[t] != 2'h0) begin
                busy[t] <= busy[t] - 2'h1;
            end
        end
    end
    // drops at once on a transfer so a loser must really wait
    always_comb begin
        for (int t = 0; t < 3; t++) begin
            T_READY[t] = !(SLOW && (T_REQ[t].valid || busy[t] != 2'h0));
        end
    end
endmodule : xbp_tgt_model

// [dv/tb_top.sv]
// self-checking bench for the crossbar priority arbiter
`timescale 1ns/1ps
module tb_top;
    import xbp_pkg::*;
    typedef struct packed {
        logic [2:0] v;
        logic [5:0] t;
        logic [2:0] r;
        logic [2:0] mc;
        logic [2:0] g;
        logic [2:0] tv;
    } xbp_row_s;
    // ****************************************
    // signals and instances
    // ****************************************
    logic                  clk = 1'b0;
    logic                  reset = 1'b1;
    xbp_req_s [2:0]        m_req = '0;
    logic     [2:0]        m_gnt, m_err, t_ready, mdl_rdy;
    logic     [2:0]        rdy = 3'h7;
    xbp_tgt_s [2:0]        t_req;
    logic     [2:0]        mc = 3'h0;
    logic     [3:0]        mc_gnt;
    logic                  win_en = 1'b0;
    logic                  page_wr = 1'b0;
    logic                  slow = 1'b0;
    logic     [15:0]       page_val = 16'h0000;
    logic     [15:0]       host_page;
    int                    failures = 0;
    int                    compares = 0;
    int                    w;
    always #20 clk = ~clk;
    assign t_ready = rdy & mdl_rdy;
    xbp_crossbar i_xbp_crossbar (.CLK(clk), .RESET(reset), .M_REQ(m_req), .M_GNT(m_gnt), .M_ERR(m_err),
        .T_READY(t_ready), .T_REQ(t_req), .CORE_D0_REQ(mc[0]), .CORE_D1_REQ(mc[1]), .FETCH_REQ(mc[2]),
        .MC_GNT(mc_gnt), .HOST_WIN_EN(win_en), .PAGE_WR(page_wr), .PAGE_VAL(page_val), .HOST_PAGE(host_page));
    xbp_tgt_model i_xbp_tgt_model (.CLK(clk), .RESET(reset), .SLOW(slow), .T_REQ(t_req), .T_READY(mdl_rdy));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // memory slots by order d0, d1, shared, fetch; three at most
    function automatic logic [3:0] mcx(input logic [3:0] r);
        logic [3:0] g;
        int         n;
        g = 4'h0;
        n = 0;
        for (int i = 0; i < 4; i++) begin
            if (r[i] && n < 3) begin
                g[i] = 1'b1;
                n++;
            end
        end
        return g;
    endfunction : mcx
    function automatic logic [31:0] adr(input logic [1:0] t);
        return {(t == 2'h1) ? 4'h4 : (t == 2'h2) ? 4'h8 : 4'h0, 28'h0000010};
    endfunction : adr
    function automatic logic [2:0] tvs();
        return {t_req[2].valid, t_req[1].valid, t_req[0].valid};
    endfunction : tvs
    task automatic host(input logic [31:0] a, input logic [2:0] e, input logic [2:0] tv);
        @(negedge clk);
        m_req[1] = '{valid: 1'b1, write: 1'b1, addr: a, wdata: 32'hA5A5_0001};
        #1 chk("host gnt", m_gnt, 3'h2);
        @(negedge clk);
        m_req[1].valid = 1'b0;
        #1 chk("host err", m_err, e);
        chk("host fwd", tvs(), tv);
        chk("host src", t_req[0].src, tv[0] ? 2'h1 : 2'h0);
        chk("host wr", t_req[0].write, tv[0]);
        chk("host wd", t_req[0].wdata, tv[0] ? 32'hA5A5_0001 : 32'h0);
        chk("host mc", mc_gnt, {1'b0, tv[0], 2'b00});
    endtask : host
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    // ****************************************
    // table: parallel paths, priority, memory slots
    // ****************************************
    xbp_row_s rows [7] = '{
        '{3'b111, 6'b011000, 3'b111, 3'b000, 3'b111, 3'b111},
        '{3'b111, 6'b000000, 3'b111, 3'b011, 3'b100, 3'b001},
        '{3'b011, 6'b001010, 3'b111, 3'b111, 3'b010, 3'b100},
        '{3'b100, 6'b000000, 3'b001, 3'b111, 3'b100, 3'b001},
        '{3'b101, 6'b000010, 3'b111, 3'b000, 3'b101, 3'b101},
        '{3'b011, 6'b000000, 3'b111, 3'b000, 3'b010, 3'b001},
        '{3'b111, 6'b101010, 3'b111, 3'b000, 3'b100, 3'b100}};
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        #1 chk("rst page", host_page, 16'h0000);
        chk("rst err", m_err, 3'h0);
        chk("rst fwd", tvs(), 3'h0);
        foreach (rows[k]) begin
            @(negedge clk);
            for (int m = 0; m < 3; m++) begin
                m_req[m] = '{valid: rows[k].v[m], write: 1'b0, addr: adr(rows[k].t[2*m+:2]), wdata: 32'(m)};
            end
            rdy = rows[k].r;
            mc = rows[k].mc;
            #1 chk("grant", m_gnt, rows[k].g);
            chk("mc row", mc_gnt, mcx({mc[2], 1'b0, mc[1:0]}));
            @(negedge clk);
            m_req = '0;
            #1 chk("forward", tvs(), rows[k].tv);
            chk("mc shared", mc_gnt, mcx({mc[2], rows[k].tv[0], mc[1:0]}));
            mc = 3'h0;
        end
        rdy = 3'h7;
        // ****************************************
        // host reach, window and page
        // ****************************************
        host(32'h4000_0000, 3'h2, 3'h0);
        @(negedge clk);
        win_en = 1'b1;
        page_wr = 1'b1;
        page_val = 16'h0012;
        @(negedge clk);
        page_wr = 1'b0;
        #1 chk("page", host_page, 16'h0012);
        host(32'h0012_0040, 3'h0, 3'h1);
        host(32'h0013_0000, 3'h2, 3'h0);
        // ****************************************
        // stalled loser stays pending
        // ****************************************
        @(negedge clk);
        slow = 1'b1;
        m_req[0] = '{valid: 1'b1, write: 1'b0, addr: 32'h8000_0100, wdata: 32'h0};
        m_req[2] = '{valid: 1'b1, write: 1'b0, addr: 32'h8000_0200, wdata: 32'h2};
        #1 chk("pend gnt", m_gnt, 3'h4);
        @(negedge clk);
        m_req[2].valid = 1'b0;
        #1 chk("pend src", t_req[2].src, 2'h2);
        chk("pend addr", t_req[2].addr, 32'h8000_0200);
        chk("pend data", t_req[2].wdata, 32'h2);
        for (w = 0; w < 8 && m_gnt[0] !== 1'b1; w++) begin
            @(negedge clk);
            #1;
        end
        if (w == 8) begin
            failures++;
            give_verdict();
        end
        chk("pend wait", w, 3);
        @(negedge clk);
        m_req = '0;
        slow = 1'b0;
        reset = 1'b1;
        #1 chk("pend late", t_req[2].src, 2'h0);
        chk("pend late v", t_req[2].valid, 1'b1);
        chk("pend late a", t_req[2].addr, 32'h8000_0100);
        // ****************************************
        // second reset clears page and forwards
        // ****************************************
        @(negedge clk);
        reset = 1'b0;
        #1 chk("rst2 page", host_page, 16'h0000);
        chk("rst2 fwd", tvs(), 3'h0);
        give_verdict();
    end
endmodule : tb_top
